// [rtl/tte_params.svh]
`ifndef TTE_PARAMS_SVH
`define TTE_PARAMS_SVH

// register index of the option register; its byte address is four times it
`define TTE_OPT_IDX      32'hfffff5a5
`define TTE_ADDR_W       12
`define TTE_OPT_ADDR     12'h694
`define TTE_IOC2_ADDR    12'h000
`define TTE_STAT_ADDR    12'h004
`define TTE_IRQ_ST_ADDR  12'h008
`define TTE_IRQ_MSK_ADDR 12'h00c

// option register fields
`define TTE_OPT_OVF      0
`define TTE_OPT_CC0      4
`define TTE_OPT_CC1      5
`define TTE_OPT_WMASK    8'h31
`define TTE_OPT_RST      8'h00

// io control two fields
`define TTE_IOC2_TRIG_LO 0
`define TTE_IOC2_EVT_LO  2
`define TTE_IOC2_WMASK   8'h0f
`define TTE_IOC2_RST     8'h00

// interrupt status bits
`define TTE_IRQ_TRIG     0
`define TTE_IRQ_EVT      1
`define TTE_IRQ_OVF      2
`define TTE_IRQ_N        3

`define TTE_RESP_OKAY    2'b00
`define TTE_RESP_SLVERR  2'b10

`endif

// [rtl/tte_pkg.sv]
package tte_pkg;

    typedef enum logic [1:0] {
        TTE_EDGE_NONE = 2'b00,
        TTE_EDGE_RISE = 2'b01,
        TTE_EDGE_FALL = 2'b10,
        TTE_EDGE_BOTH = 2'b11
    } tte_edge_e;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic rise;
        logic fall;
    } tte_sync_s;

    typedef struct packed {
        logic        aw_got;
        logic [11:0] aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [7:0]  opt;
        logic [7:0]  ioc2;
        logic [2:0]  irq_st;
        logic [2:0]  irq_mask;
        logic        irq;
        logic        trig_pulse;
        logic        evt_pulse;
        logic        cc0_cap;
        logic        cc1_cap;
    } tte_state_s;

endpackage : tte_pkg

// [rtl/tte_pin_sync.sv]
`timescale 1ns/1ns
module tte_pin_sync (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic pin_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    tte_pkg::tte_sync_s s;
    tte_pkg::tte_sync_s next_s;

    always_comb begin
        next_s       = s;
        next_s.s1    = pin_in;
        next_s.s2    = s.s1;
        next_s.s3    = s.s2;
        next_s.rise  = 1'b0;
        next_s.fall  = 1'b0;
        // a change counts only once the two later stages agree
        if (s.s2 == s.s3 && s.s3 != s.level) begin
            next_s.level = s.s3;
            next_s.rise  = s.s3;
            next_s.fall  = ~s.s3;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign level = s.level;
    assign rise  = s.rise;
    assign fall  = s.fall;

    pulse_excl_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !(rise && fall)) else $error("rise and fall together");
endmodule : tte_pin_sync

// [rtl/tte_top.sv]
// Contract
// R1: trigger edge field 00 off, 01 rising, 10 falling, 11 both edges.
// R2: 8-bit option register sets capture/compare selects and holds overflow flag.
// R3: option register readable and writable whole byte or single bit; code writes byte lane 0 only, a single bit by read-modify-write.
// R4: reset clears option register, both selects and overflow flag.
// R5: io control two holds event and trigger edge fields, resets zero.
// R6: select bit 0 makes register compare, 1 makes it capture.
// R7: second register select honoured only in free-running mode.
// R8: software changes edge fields only while counter enable is zero; writes are not blocked while counting.
`timescale 1ns/1ns
`include "tte_params.svh"
module tte_top (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        shared_input_pin,
    input  wire logic        ovf_event,
    input  wire logic        counter_enable_bit,
    input  wire logic        free_run_mode,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             trig_pulse,
    output logic             evt_pulse,
    output logic             cc0_capture_mode,
    output logic             cc1_capture_mode,
    output logic             irq
);
    tte_pkg::tte_state_s s;
    tte_pkg::tte_state_s next_s;
    logic                pin_level;
    logic                pin_rise;
    logic                pin_fall;
    logic                wr_fire;
    logic                trig_hit;
    logic                evt_hit;

    tte_pin_sync u_pin (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .pin_in   (shared_input_pin),
        .level    (pin_level),
        .rise     (pin_rise),
        .fall     (pin_fall)
    );

    function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
        case (tte_pkg::tte_edge_e'(sel))
            tte_pkg::TTE_EDGE_RISE: edge_hit = r;
            tte_pkg::TTE_EDGE_FALL: edge_hit = f;
            tte_pkg::TTE_EDGE_BOTH: edge_hit = r | f;
            default:                edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    // one shared pin, two independent edge selections
    assign trig_hit = edge_hit(s.ioc2[`TTE_IOC2_TRIG_LO +: 2], pin_rise, pin_fall); // see R1
    assign evt_hit  = edge_hit(s.ioc2[`TTE_IOC2_EVT_LO +: 2], pin_rise, pin_fall);  // see R5
    assign wr_fire  = s.aw_got & s.w_got & ~s.bvalid;

    always_comb begin
        logic [2:0] ev;
        logic       hit;
        next_s            = s;
        ev                = '0;
        hit               = 1'b1;
        ev[`TTE_IRQ_TRIG] = trig_hit;
        ev[`TTE_IRQ_EVT]  = evt_hit;
        ev[`TTE_IRQ_OVF]  = ovf_event;

        if (s_axi_awvalid && s.awready) begin
            next_s.aw_got  = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            next_s.w_got  = 1'b1;
            next_s.w_data = s_axi_wdata;
            next_s.w_strb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        // byte lane 0 only; single-bit change is a read-modify-write of the byte
        if (wr_fire) begin
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
            next_s.bvalid = 1'b1;
            if (s.aw_addr == `TTE_OPT_ADDR) begin
                if (s.w_strb[0]) begin
                    next_s.opt = s.w_data[7:0] & `TTE_OPT_WMASK; // see R2, R3
                end
            end else if (s.aw_addr == `TTE_IOC2_ADDR) begin
                // rewriting while counting is the user's hazard, not blocked here
                if (s.w_strb[0]) begin
                    next_s.ioc2 = s.w_data[7:0] & `TTE_IOC2_WMASK; // see R5, R8
                end
            end else if (s.aw_addr == `TTE_IRQ_ST_ADDR) begin
                if (s.w_strb[0]) begin
                    next_s.irq_st = s.irq_st & ~s.w_data[2:0];
                end
            end else if (s.aw_addr == `TTE_IRQ_MSK_ADDR) begin
                if (s.w_strb[0]) begin
                    next_s.irq_mask = s.w_data[2:0];
                end
            end else if (s.aw_addr != `TTE_STAT_ADDR) begin
                hit = 1'b0;
            end
            next_s.bresp = hit ? `TTE_RESP_OKAY : `TTE_RESP_SLVERR;
        end

        // hardware set wins over a same-cycle software clear
        if (ovf_event) begin
            next_s.opt[`TTE_OPT_OVF] = 1'b1; // see R2
        end
        next_s.irq_st = next_s.irq_st | ev;

        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = `TTE_RESP_OKAY;
            next_s.rdata  = '0;
            if (s_axi_araddr == `TTE_OPT_ADDR) begin
                next_s.rdata[7:0] = s.opt; // see R3
            end else if (s_axi_araddr == `TTE_IOC2_ADDR) begin
                next_s.rdata[7:0] = s.ioc2;
            end else if (s_axi_araddr == `TTE_STAT_ADDR) begin
                next_s.rdata[2:0] = {counter_enable_bit, free_run_mode, pin_level};
            end else if (s_axi_araddr == `TTE_IRQ_ST_ADDR) begin
                next_s.rdata[2:0] = s.irq_st;
            end else if (s_axi_araddr == `TTE_IRQ_MSK_ADDR) begin
                next_s.rdata[2:0] = s.irq_mask;
            end else begin
                next_s.rresp = `TTE_RESP_SLVERR;
            end
        end

        next_s.awready    = ~next_s.aw_got & ~next_s.bvalid;
        next_s.wready     = ~next_s.w_got & ~next_s.bvalid;
        next_s.arready    = ~next_s.rvalid;
        next_s.trig_pulse = trig_hit;
        next_s.evt_pulse  = evt_hit;
        next_s.cc0_cap    = next_s.opt[`TTE_OPT_CC0];                 // see R6
        next_s.cc1_cap    = next_s.opt[`TTE_OPT_CC1] & free_run_mode; // see R6, R7
        next_s.irq        = |(next_s.irq_st & next_s.irq_mask);
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s          <= '0; // see R4, R5
            s.awready  <= 1'b1;
            s.wready   <= 1'b1;
            s.arready  <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign s_axi_awready    = s.awready;
    assign s_axi_wready     = s.wready;
    assign s_axi_bvalid     = s.bvalid;
    assign s_axi_bresp      = s.bresp;
    assign s_axi_arready    = s.arready;
    assign s_axi_rvalid     = s.rvalid;
    assign s_axi_rdata      = s.rdata;
    assign s_axi_rresp      = s.rresp;
    assign trig_pulse       = s.trig_pulse;
    assign evt_pulse        = s.evt_pulse;
    assign cc0_capture_mode = s.cc0_cap;
    assign cc1_capture_mode = s.cc1_cap;
    assign irq              = s.irq;

    // takes the status word as an argument so the assertion sees its sampled value
    function automatic logic irq_st_ovf(input logic [2:0] st);
        irq_st_ovf = st[`TTE_IRQ_OVF];
    endfunction : irq_st_ovf

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    trig_rise_a: assert property ((s.ioc2[1:0] == 2'b01 && pin_rise) |=> trig_pulse) // see R1
        else $error("rising trigger missed");
    trig_wrong_a: assert property ((s.ioc2[1:0] == 2'b10 && pin_rise) |=> !trig_pulse) // see R1
        else $error("falling select fired on rise");
    trig_off_a: assert property (trig_pulse |-> $past(s.ioc2[1:0]) != 2'b00) // see R1
        else $error("trigger fired while disabled");
    opt_layout_a: assert property (s.opt[7:6] == 2'b00 && s.opt[3:1] == 3'b000) // see R2
        else $error("option reserved bits set");
    ovf_set_a: assert property (ovf_event |=> s.opt[`TTE_OPT_OVF] // see R2
        && irq_st_ovf(s.irq_st))
        else $error("overflow not flagged");
    opt_write_a: assert property ((wr_fire && s.aw_addr == `TTE_OPT_ADDR && s.w_strb[0]) // see R3
        |=> s.opt[5:4] == $past(s.w_data[5:4]))
        else $error("option write lost");
    opt_keep_a: assert property ((wr_fire && s.aw_addr == `TTE_OPT_ADDR && !s.w_strb[0]) // see R3
        |=> $stable(s.opt[5:4]))
        else $error("option changed without lane 0");
    opt_reset_a: assert property (@(posedge core_clk) $past(sys_rst) // see R4
        |-> s.opt == `TTE_OPT_RST)
        else $error("option not cleared by reset");
    ioc2_reset_a: assert property (@(posedge core_clk) $past(sys_rst) // see R5
        |-> s.ioc2 == `TTE_IOC2_RST)
        else $error("io control not cleared by reset");
    cc0_mode_a: assert property ((wr_fire && s.aw_addr == `TTE_OPT_ADDR && s.w_strb[0]) // see R6
        |=> cc0_capture_mode == $past(s.w_data[`TTE_OPT_CC0]))
        else $error("cc0 mode mismatch");
    cc1_gate_a: assert property (cc1_capture_mode == // see R7
        (s.opt[`TTE_OPT_CC1] && $past(free_run_mode)))
        else $error("cc1 select not gated");
    write_resp_a: assert property (wr_fire |=> s_axi_bvalid ##0 (s.aw_got == 1'b0))
        else $error("write response missing");

    both_edges_c: cover property (s.ioc2[1:0] == 2'b11 && pin_fall ##1 trig_pulse);
    ovf_irq_c: cover property (ovf_event ##[1:3] irq);
    opt_read_c: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr == `TTE_OPT_ADDR);
    cc1_free_c: cover property (cc1_capture_mode);
endmodule : tte_top

// [verif/tte_pin_model.sv]
`timescale 1ns/1ns
module tte_pin_model #(
    parameter int HOLD = 8
) (
    input  wire logic core_clk,
    output logic      pin
);
    initial pin = 1'h0;
    // each level stands well past the two-cycle minimum so the synchroniser sees it
    task automatic drive(input logic v);
        @(posedge core_clk);
        pin <= v;
        repeat (HOLD) @(posedge core_clk);
    endtask : drive
endmodule : tte_pin_model

// [verif/timer_trigger_edge_and_option_tb_top.sv]
`timescale 1ns/1ns
`include "tte_params.svh"
module timer_trigger_edge_and_option_tb_top;
    logic        core_clk = 1'h0;
    logic        sys_rst = 1'h1;
    logic        ovf_event = 1'h0, counter_enable_bit = 1'h0, free_run_mode = 1'h0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = '0;
    logic [3:0]  wstrb_sel = 4'h1;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic        shared_input_pin, trig_pulse, evt_pulse, cc0_capture_mode, cc1_capture_mode, irq;
    int          fails = 0, checks = 0, trig_cnt = 0, evt_cnt = 0, tb, eb;
    logic [7:0]  row_ioc2 [4] = '{8'h00, 8'h09, 8'h06, 8'h0f};
    int          row_trig [4] = '{0, 1, 1, 2};
    int          row_evt  [4] = '{0, 1, 1, 2};

    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        trig_cnt <= trig_cnt + int'(trig_pulse === 1'h1);
        evt_cnt  <= evt_cnt + int'(evt_pulse === 1'h1);
    end

    tte_top tte_top_inst (.core_clk, .sys_rst, .shared_input_pin, .ovf_event, .counter_enable_bit,
        .free_run_mode, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .trig_pulse, .evt_pulse, .cc0_capture_mode, .cc1_capture_mode, .irq);
    tte_pin_model tte_pin_model_inst (.core_clk, .pin(shared_input_pin));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge core_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h0, d};
        s_axi_wstrb   <= wstrb_sel;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        do begin
            @(posedge core_clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!(s_axi_bvalid === 1'h1 && s_axi_bready) && n < 200);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        check(32'(n < 200), 32'h1, "write answer");
    endtask : wr

    task automatic rc(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge core_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        do begin
            @(posedge core_clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!(s_axi_rvalid === 1'h1 && s_axi_rready) && n < 200);
        check(s_axi_rdata, exp, "read data");
        check(32'(s_axi_rresp), 32'(er), "read response");
        s_axi_rready <= 1'h0;
    endtask : rc

    task automatic settle;
        repeat (3) @(posedge core_clk);
    endtask : settle

    task automatic summarize;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (5000) @(posedge core_clk);
        fails++;
        summarize();
    end

    initial begin
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'h0;
        rc(`TTE_OPT_ADDR, 32'h0, `TTE_RESP_OKAY);
        rc(`TTE_IOC2_ADDR, 32'h0, `TTE_RESP_OKAY);
        check({cc0_capture_mode, cc1_capture_mode, irq}, 32'h0, "reset outputs");
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            wr(`TTE_IOC2_ADDR, row_ioc2[i], resp);
            rc(`TTE_IOC2_ADDR, 32'(row_ioc2[i]), `TTE_RESP_OKAY);
            tb = trig_cnt;
            eb = evt_cnt;
            tte_pin_model_inst.drive(1'h1);
            tte_pin_model_inst.drive(1'h0);
            check(trig_cnt - tb, row_trig[i], "trigger edges");
            check(evt_cnt - eb, row_evt[i], "event edges");
        end
        $display("test edge table done");
        free_run_mode <= 1'h1;
        wr(`TTE_OPT_ADDR, 8'hff, resp);
        rc(`TTE_OPT_ADDR, 32'h31, `TTE_RESP_OKAY);
        settle();
        check({cc0_capture_mode, cc1_capture_mode}, 32'h3, "capture modes");
        free_run_mode <= 1'h0;
        settle();
        check({cc0_capture_mode, cc1_capture_mode}, 32'h2, "cc1 outside free run");
        // single-bit access is a read-modify-write of the byte
        wr(`TTE_OPT_ADDR, 8'h21, resp);
        rc(`TTE_OPT_ADDR, 32'h21, `TTE_RESP_OKAY);
        settle();
        check(cc0_capture_mode, 1'h0, "cc0 compare");
        // a write without byte lane 0 must leave the option byte alone
        wstrb_sel = 4'h2;
        wr(`TTE_OPT_ADDR, 8'h10, resp);
        wstrb_sel = 4'h1;
        rc(`TTE_OPT_ADDR, 32'h21, `TTE_RESP_OKAY);
        wr(`TTE_OPT_ADDR, 8'h00, resp);
        wr(`TTE_IRQ_ST_ADDR, 8'h07, resp);
        $display("test option done");
        @(posedge core_clk);
        ovf_event <= 1'h1;
        @(posedge core_clk);
        ovf_event <= 1'h0;
        rc(`TTE_OPT_ADDR, 32'h01, `TTE_RESP_OKAY);
        rc(`TTE_IRQ_ST_ADDR, 32'h04, `TTE_RESP_OKAY);
        check(irq, 1'h0, "masked irq");
        wr(`TTE_IRQ_MSK_ADDR, 8'h04, resp);
        settle();
        check(irq, 1'h1, "unmasked irq");
        wr(`TTE_IRQ_ST_ADDR, 8'h04, resp);
        settle();
        check(irq, 1'h0, "cleared irq");
        wr(`TTE_OPT_ADDR, 8'h00, resp);
        rc(`TTE_OPT_ADDR, 32'h0, `TTE_RESP_OKAY);
        $display("test overflow done");
        counter_enable_bit <= 1'h1;
        free_run_mode <= 1'h1;
        settle();
        rc(`TTE_STAT_ADDR, 32'h06, `TTE_RESP_OKAY);
        rc(12'h010, 32'h0, `TTE_RESP_SLVERR);
        wr(12'h010, 8'hff, resp);
        check(32'(resp), 32'(`TTE_RESP_SLVERR), "unmapped write");
        wr(`TTE_OPT_ADDR, 8'h31, resp);
        sys_rst <= 1'h1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'h0;
        rc(`TTE_OPT_ADDR, 32'h0, `TTE_RESP_OKAY);
        rc(`TTE_IOC2_ADDR, 32'h0, `TTE_RESP_OKAY);
        $display("test misc and reset done");
        summarize();
    end
endmodule : timer_trigger_edge_and_option_tb_top
